// ### verilog/gsm_regs.vh
// Register map, field positions and reset values of the gripper safety monitor
`ifndef GSM_REGS_VH
`define GSM_REGS_VH

`define GSM_ADDR_W 5
`define GSM_OFS_CTRL 5'h00
`define GSM_OFS_STATUS 5'h04
`define GSM_OFS_IRQ_STAT 5'h08
`define GSM_OFS_IRQ_EN 5'h0C
`define GSM_OFS_IRQ_CLR 5'h10

`define GSM_CTRL_SOFT_STOP 0
`define GSM_CTRL_RST 1'h0

`define GSM_ST_STATE_LSB 0
`define GSM_ST_STATE_MSB 2
`define GSM_ST_SENS_LSB 4
`define GSM_ST_SENS_MSB 7
`define GSM_ST_POWER 8
`define GSM_ST_ERROR 9
`define GSM_ST_AGREE 10

`define GSM_IRQ_W 4
`define GSM_IRQ_HOLD 0
`define GSM_IRQ_CUTOFF 1
`define GSM_IRQ_PANIC 2
`define GSM_IRQ_RELEASE 3
`define GSM_IRQ_RST 4'h0

`define GSM_SENS_OPEN1 0
`define GSM_SENS_OPEN2 1
`define GSM_SENS_CLOSE1 2
`define GSM_SENS_CLOSE2 3

`define GSM_RESP_OKAY 2'h0
`define GSM_RESP_SLVERR 2'h2

`endif

// ### verilog/gsm_sync.v
// Two-stage synchroniser for a group of asynchronous pin inputs
`timescale 1ns/1ps
module gsm_sync #(
  parameter W = 1
) (
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  input wire [W-1:0] async_i,
  output reg [W-1:0] sync_o
);
  reg [W-1:0] meta;

  always @(posedge clk_i) begin
    if (rst_i) begin
      meta <= {W{1'b0}};
      sync_o <= {W{1'b0}};
    end else if (ce_i) begin
      meta <= async_i;
      sync_o <= meta;
    end
  end
endmodule

// ### verilog/gsm_top.v
// Gripper safety monitor: mode and safe-state logic with AXI4-Lite registers
`timescale 1ns/1ps
`include "gsm_regs.vh"
module gsm_top (
  input wire CLK_I,
  input wire RST_I,
  input wire CE_I,
  input wire RELEASE_I,
  input wire ENABLE_I,
  input wire ESTOP_I,
  input wire CONFIRM_I,
  input wire AGREE_I,
  input wire ACK_I,
  input wire OPEN_CMD_I,
  input wire CLOSE_CMD_I,
  input wire [3:0] SENSOR_I,
  output reg [3:0] SENSOR_O,
  output reg POWER_EN_O,
  output reg OPEN_O,
  output reg CLOSE_O,
  output reg ERROR_O,
  output wire IRQ_O,
  input wire [`GSM_ADDR_W-1:0] S_AXI_AWADDR,
  input wire S_AXI_AWVALID,
  output wire S_AXI_AWREADY,
  input wire [31:0] S_AXI_WDATA,
  input wire [3:0] S_AXI_WSTRB,
  input wire S_AXI_WVALID,
  output wire S_AXI_WREADY,
  output reg [1:0] S_AXI_BRESP,
  output reg S_AXI_BVALID,
  input wire S_AXI_BREADY,
  input wire [`GSM_ADDR_W-1:0] S_AXI_ARADDR,
  input wire S_AXI_ARVALID,
  output wire S_AXI_ARREADY,
  output reg [31:0] S_AXI_RDATA,
  output reg [1:0] S_AXI_RRESP,
  output reg S_AXI_RVALID,
  input wire S_AXI_RREADY
);
  localparam ST_RELEASE = 3'h0;
  localparam ST_HOLD = 3'h1;
  localparam ST_CUTOFF = 3'h2;
  localparam ST_ACKED = 3'h3;
  localparam ST_PANIC = 3'h4;

  // Pin inputs cross into the clock domain first
  wire [7:0] pins_s;
  wire rel_s = pins_s[0];
  wire ena_s = pins_s[1];
  wire estop_s = pins_s[2];
  wire conf_s = pins_s[3];
  wire agree_s = pins_s[4];
  wire ack_s = pins_s[5];
  wire open_s = pins_s[6];
  wire close_s = pins_s[7];
  wire [3:0] sens_s;

  gsm_sync #(.W(8)) u_sync_cmd (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .ce_i(CE_I),
    .async_i({CLOSE_CMD_I, OPEN_CMD_I, ACK_I, AGREE_I, CONFIRM_I, ESTOP_I, ENABLE_I,
              RELEASE_I}),
    .sync_o(pins_s)
  );

  gsm_sync #(.W(4)) u_sync_sens (
    .clk_i(CLK_I),
    .rst_i(RST_I),
    .ce_i(CE_I),
    .async_i(SENSOR_I),
    .sync_o(sens_s)
  );

  reg [2:0] state;
  reg [2:0] next_state;
  reg [3:0] snap;
  reg ena_d;
  reg conf_d;
  reg ack_d;
  reg agree_seen;
  reg soft_stop;
  reg [`GSM_IRQ_W-1:0] irq_stat;
  reg [`GSM_IRQ_W-1:0] irq_en;

  // Redundant pairs must agree and never report open and closed together
  function plausible;
    input [3:0] s;
    begin
      plausible = (s[`GSM_SENS_OPEN1] == s[`GSM_SENS_OPEN2]) &&
                  (s[`GSM_SENS_CLOSE1] == s[`GSM_SENS_CLOSE2]) &&
                  !(s[`GSM_SENS_OPEN1] && s[`GSM_SENS_CLOSE1]);
    end
  endfunction

  wire ena_rise = ena_s && !ena_d;
  wire conf_rise = conf_s && !conf_d;
  wire ack_rise = ack_s && !ack_d;
  // Release present, no stop request from pin or software
  wire release_ok = rel_s && !estop_s && !soft_stop;
  wire undefined_pos = (sens_s != snap) || !plausible(sens_s);

  always @* begin
    next_state = state;
    case (state)
      ST_RELEASE: begin
        if (!release_ok)
          next_state = ST_HOLD;
      end
      ST_HOLD: begin
        if (undefined_pos)
          next_state = ST_CUTOFF;
        else if ((ena_rise || conf_rise) && release_ok)
          next_state = ST_RELEASE;
      end
      ST_CUTOFF: begin
        // Enable is not looked at here, so it cannot skip the acknowledge
        if (agree_seen && conf_rise)
          next_state = ST_PANIC;
        else if (ack_rise && plausible(sens_s))
          next_state = ST_ACKED;
      end
      ST_ACKED: begin
        if (!plausible(sens_s))
          next_state = ST_CUTOFF;
        else if (ena_rise && release_ok)
          next_state = ST_RELEASE;
      end
      ST_PANIC: begin
        if (!conf_s)
          next_state = ST_CUTOFF;
      end
      default: next_state = ST_CUTOFF;
    endcase
  end

  always @(posedge CLK_I) begin
    if (RST_I) begin
      state <= ST_CUTOFF;
      snap <= 4'h0;
      ena_d <= 1'b0;
      conf_d <= 1'b0;
      ack_d <= 1'b0;
      agree_seen <= 1'b0;
    end else if (CE_I) begin
      state <= next_state;
      ena_d <= ena_s;
      conf_d <= conf_s;
      ack_d <= ack_s;
      // Snapshot taken on entry to monitoring; position is then watched
      if (next_state == ST_HOLD && state != ST_HOLD)
        snap <= sens_s;
      if (state != ST_CUTOFF)
        agree_seen <= 1'b0;
      else if (agree_s)
        agree_seen <= 1'b1;
    end
  end

  // Gripper side outputs
  always @(posedge CLK_I) begin
    if (RST_I) begin
      SENSOR_O <= 4'h0;
      POWER_EN_O <= 1'b0;
      OPEN_O <= 1'b0;
      CLOSE_O <= 1'b0;
      ERROR_O <= 1'b1;
    end else if (CE_I) begin
      SENSOR_O <= sens_s;
      POWER_EN_O <= (next_state == ST_RELEASE) || (next_state == ST_HOLD) ||
                    (next_state == ST_PANIC);
      ERROR_O <= (next_state == ST_CUTOFF) || (next_state == ST_ACKED);
      // Commands are frozen at their last value outside release mode
      if (state == ST_RELEASE && next_state == ST_RELEASE) begin
        OPEN_O <= open_s;
        CLOSE_O <= close_s;
      end
    end
  end

  // Interrupt events: entries into each mode except ST_ACKED
  wire entering = (next_state != state);
  reg [`GSM_IRQ_W-1:0] irq_evt;
  always @* begin
    irq_evt = `GSM_IRQ_RST;
    irq_evt[`GSM_IRQ_HOLD] = entering && (next_state == ST_HOLD);
    irq_evt[`GSM_IRQ_CUTOFF] = entering && (next_state == ST_CUTOFF);
    irq_evt[`GSM_IRQ_PANIC] = entering && (next_state == ST_PANIC);
    irq_evt[`GSM_IRQ_RELEASE] = entering && (next_state == ST_RELEASE);
  end

  assign IRQ_O = |(irq_stat & irq_en);

  // AXI4-Lite slave
  reg aw_full;
  reg [`GSM_ADDR_W-1:0] aw_addr;
  reg w_full;
  reg [31:0] w_data;
  reg [3:0] w_strb;

  assign S_AXI_AWREADY = !aw_full && !S_AXI_BVALID;
  assign S_AXI_WREADY = !w_full && !S_AXI_BVALID;
  assign S_AXI_ARREADY = !S_AXI_RVALID;

  wire do_write = aw_full && w_full && !S_AXI_BVALID;
  wire wr_ctrl = do_write && (aw_addr == `GSM_OFS_CTRL) && w_strb[0];
  wire wr_en = do_write && (aw_addr == `GSM_OFS_IRQ_EN) && w_strb[0];
  wire wr_clr = do_write && (aw_addr == `GSM_OFS_IRQ_CLR) && w_strb[0];

  function known_addr;
    input [`GSM_ADDR_W-1:0] a;
    begin
      known_addr = (a == `GSM_OFS_CTRL) || (a == `GSM_OFS_STATUS) ||
                   (a == `GSM_OFS_IRQ_STAT) || (a == `GSM_OFS_IRQ_EN) ||
                   (a == `GSM_OFS_IRQ_CLR);
    end
  endfunction

  // Low address bits are ignored: every register is one aligned word
  function [`GSM_ADDR_W-1:0] word_of;
    input [`GSM_ADDR_W-1:0] a;
    begin
      word_of = {a[`GSM_ADDR_W-1:2], 2'h0};
    end
  endfunction

  function writable;
    input [`GSM_ADDR_W-1:0] a;
    begin
      writable = known_addr(a) && (a != `GSM_OFS_STATUS) && (a != `GSM_OFS_IRQ_STAT);
    end
  endfunction

  // Clear register is write-only and answers reads with an error
  function readable;
    input [`GSM_ADDR_W-1:0] a;
    begin
      readable = known_addr(a) && (a != `GSM_OFS_IRQ_CLR);
    end
  endfunction

  wire [`GSM_ADDR_W-1:0] ar_word = word_of(S_AXI_ARADDR);

  always @(posedge CLK_I) begin
    if (RST_I) begin
      aw_full <= 1'b0;
      aw_addr <= {`GSM_ADDR_W{1'b0}};
      w_full <= 1'b0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      S_AXI_BVALID <= 1'b0;
      S_AXI_BRESP <= `GSM_RESP_OKAY;
    end else if (CE_I) begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_full <= 1'b1;
        aw_addr <= word_of(S_AXI_AWADDR);
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_full <= 1'b1;
        w_data <= S_AXI_WDATA;
        w_strb <= S_AXI_WSTRB;
      end
      if (do_write) begin
        aw_full <= 1'b0;
        w_full <= 1'b0;
        S_AXI_BVALID <= 1'b1;
        S_AXI_BRESP <= writable(aw_addr) ? `GSM_RESP_OKAY : `GSM_RESP_SLVERR;
      end else if (S_AXI_BVALID && S_AXI_BREADY) begin
        S_AXI_BVALID <= 1'b0;
      end
    end
  end

  // Software registers; a new event wins over a clear in the same cycle
  always @(posedge CLK_I) begin
    if (RST_I) begin
      soft_stop <= `GSM_CTRL_RST;
      irq_en <= `GSM_IRQ_RST;
      irq_stat <= `GSM_IRQ_RST;
    end else if (CE_I) begin
      if (wr_ctrl)
        soft_stop <= w_data[`GSM_CTRL_SOFT_STOP];
      if (wr_en)
        irq_en <= w_data[`GSM_IRQ_W-1:0];
      irq_stat <= (irq_stat & ~(wr_clr ? w_data[`GSM_IRQ_W-1:0] : `GSM_IRQ_RST)) | irq_evt;
    end
  end

  reg [31:0] rd_mux;
  always @* begin
    rd_mux = 32'h0;
    case (ar_word)
      `GSM_OFS_CTRL: rd_mux[`GSM_CTRL_SOFT_STOP] = soft_stop;
      `GSM_OFS_STATUS: begin
        rd_mux[`GSM_ST_STATE_MSB:`GSM_ST_STATE_LSB] = state;
        rd_mux[`GSM_ST_SENS_MSB:`GSM_ST_SENS_LSB] = sens_s;
        rd_mux[`GSM_ST_POWER] = POWER_EN_O;
        rd_mux[`GSM_ST_ERROR] = ERROR_O;
        rd_mux[`GSM_ST_AGREE] = agree_seen;
      end
      `GSM_OFS_IRQ_STAT: rd_mux[`GSM_IRQ_W-1:0] = irq_stat;
      `GSM_OFS_IRQ_EN: rd_mux[`GSM_IRQ_W-1:0] = irq_en;
      default: rd_mux = 32'h0;
    endcase
  end

  always @(posedge CLK_I) begin
    if (RST_I) begin
      S_AXI_RVALID <= 1'b0;
      S_AXI_RDATA <= 32'h0;
      S_AXI_RRESP <= `GSM_RESP_OKAY;
    end else if (CE_I) begin
      if (S_AXI_ARVALID && S_AXI_ARREADY) begin
        S_AXI_RVALID <= 1'b1;
        S_AXI_RDATA <= rd_mux;
        S_AXI_RRESP <= readable(ar_word) ? `GSM_RESP_OKAY : `GSM_RESP_SLVERR;
      end else if (S_AXI_RVALID && S_AXI_RREADY) begin
        S_AXI_RVALID <= 1'b0;
      end
    end
  end
endmodule

// ### sim/gsm_checker.sv
// Port-level assertions of the gripper safety monitor
`timescale 1ns/1ps
module gsm_checker (
  input wire CLK_I,
  input wire RST_I,
  input wire CE_I,
  input wire ESTOP_I,
  input wire [3:0] SENSOR_I,
  input wire [3:0] SENSOR_O,
  input wire POWER_EN_O,
  input wire OPEN_O,
  input wire CLOSE_O,
  input wire ERROR_O,
  input wire S_AXI_AWVALID,
  input wire S_AXI_AWREADY,
  input wire S_AXI_WVALID,
  input wire S_AXI_WREADY,
  input wire S_AXI_BVALID,
  input wire S_AXI_ARVALID,
  input wire S_AXI_ARREADY,
  input wire S_AXI_RVALID
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RST_I || !CE_I);
  property p_cut; ERROR_O |-> !POWER_EN_O; endproperty
  a_cut: assert property (p_cut) else $error("power on in error");
  property p_boot; $fell(RST_I) |-> ERROR_O && !POWER_EN_O; endproperty
  a_boot: assert property (p_boot) else $error("not in error after reset");
  property p_exit; $fell(ERROR_O) |-> POWER_EN_O; endproperty
  a_exit: assert property (p_exit) else $error("error left without power");
  property p_cmd; $changed({OPEN_O, CLOSE_O}) |-> POWER_EN_O && !ERROR_O; endproperty
  a_cmd: assert property (p_cmd) else $error("command moved outside release");
  property p_frz; ESTOP_I [*4] |=> $stable({OPEN_O, CLOSE_O}); endproperty
  a_frz: assert property (p_frz) else $error("command moved in stop");
  property p_sens; $stable(SENSOR_I) [*5] |-> SENSOR_O == SENSOR_I; endproperty
  a_sens: assert property (p_sens) else $error("sensor output differs");
  property p_wr;
    S_AXI_AWVALID && S_AXI_AWREADY && S_AXI_WVALID && S_AXI_WREADY |=> ##1 S_AXI_BVALID;
  endproperty
  a_wr: assert property (p_wr) else $error("write response late");
  property p_rd; S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID; endproperty
  a_rd: assert property (p_rd) else $error("read response late");
  property p_ar; S_AXI_RVALID |-> !S_AXI_ARREADY; endproperty
  a_ar: assert property (p_ar) else $error("read taken while busy");
endmodule
bind gsm_top gsm_checker gsm_checker_inst (.CLK_I, .RST_I, .CE_I, .ESTOP_I, .SENSOR_I,
  .SENSOR_O, .POWER_EN_O, .OPEN_O, .CLOSE_O, .ERROR_O, .S_AXI_AWVALID, .S_AXI_AWREADY,
  .S_AXI_WVALID, .S_AXI_WREADY, .S_AXI_BVALID, .S_AXI_ARVALID, .S_AXI_ARREADY,
  .S_AXI_RVALID);

// ### sim/gsm_gripper.sv
// Gripper finger model driving the four position sensors
`timescale 1ns/1ps
module gsm_gripper (
  input wire clk_i,
  input wire power_i,
  input wire open_i,
  input wire close_i,
  input wire yank_i,
  output reg [3:0] sens_o = 4'h3,
  output wire plaus_o
);
  // Unpowered fingers stay put; forced removal overruns both pairs
  always @(posedge clk_i) begin
    if (yank_i) begin
      sens_o <= 4'h0;
    end else if (power_i && open_i && !close_i) begin
      sens_o <= 4'h3;
    end else if (power_i && close_i && !open_i) begin
      sens_o <= 4'hC;
    end
  end
  assign plaus_o = (sens_o[0] == sens_o[1]) && (sens_o[2] == sens_o[3]) &&
                   !(sens_o[0] && sens_o[2]);
endmodule

// ### sim/tb_gsm_top.sv
// Self-checking bench: pin sequences and register accesses
`timescale 1ns/1ps
`include "gsm_regs.vh"
module tb_gsm_top;
  reg clk = 1'b0;
  reg rst = 1'b1;
  reg ce = 1'b1;
  reg rel = 1'b0, ena = 1'b0, estop = 1'b0, conf = 1'b0, agree = 1'b0, ack = 1'b0;
  reg ocmd = 1'b0, ccmd = 1'b0, yank = 1'b0;
  reg [4:0] awaddr = 5'h00, araddr = 5'h00;
  reg [31:0] wdata = 32'h0;
  reg awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  wire [3:0] sens, sens_o;
  wire pwr, open_o, close_o, err, irq, awready, wready, bvalid, arready, rvalid, plaus;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  reg [31:0] d;
  reg [1:0] r;
  integer fail_count = 0, num_checks = 0, k;
  gsm_top gsm_top_inst (.CLK_I(clk), .RST_I(rst), .CE_I(ce), .RELEASE_I(rel),
    .ENABLE_I(ena), .ESTOP_I(estop), .CONFIRM_I(conf), .AGREE_I(agree), .ACK_I(ack),
    .OPEN_CMD_I(ocmd), .CLOSE_CMD_I(ccmd), .SENSOR_I(sens), .SENSOR_O(sens_o),
    .POWER_EN_O(pwr), .OPEN_O(open_o), .CLOSE_O(close_o), .ERROR_O(err), .IRQ_O(irq),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready));
  gsm_gripper gsm_gripper_inst (.clk_i(clk), .power_i(pwr), .open_i(open_o),
    .close_i(close_o), .yank_i(yank), .sens_o(sens), .plaus_o(plaus));
  initial begin
    forever #5 clk = ~clk;
  end
  task chk(input string nm, input [31:0] e, input [31:0] g);
    begin
      num_checks = num_checks + 1;
      if (g !== e) begin
        fail_count = fail_count + 1;
        $display("unexpected %s: expected %h seen %h", nm, e, g);
      end
    end
  endtask
  task conclude;
    begin
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
    end
  endtask
  task tmo(input done);
    if (done !== 1'b1) begin
      fail_count = fail_count + 1;
      conclude;
    end
  endtask
  task wt(input integer n);
    repeat (n) @(posedge clk);
  endtask
  // Handshakes are judged on the values standing at the rising edge
  task wr(input [4:0] a, input [31:0] v, input [1:0] er);
    reg done;
    begin
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      done = 1'b0;
      for (k = 0; k < 50 && !done; k = k + 1) begin
        @(posedge clk);
        if (awvalid && awready) awvalid <= 1'b0;
        if (wvalid && wready) wvalid <= 1'b0;
        done = bvalid;
        r = bresp;
      end
      bready <= 1'b0;
      tmo(done);
      chk("bresp", er, r);
      // Idle edge so the next call never re-raises ready in this step
      @(posedge clk);
    end
  endtask
  task rd(input [4:0] a, input [1:0] er);
    reg done;
    begin
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      done = 1'b0;
      for (k = 0; k < 50 && !done; k = k + 1) begin
        @(posedge clk);
        if (arvalid && arready) arvalid <= 1'b0;
        done = rvalid;
        d = rdata;
        r = rresp;
      end
      rready <= 1'b0;
      tmo(done);
      chk("rresp", er, r);
      @(posedge clk);
    end
  endtask
  task st(input [2:0] e);
    begin
      rd(`GSM_OFS_STATUS, `GSM_RESP_OKAY);
      chk("state", e, d[2:0]);
    end
  endtask
  initial begin
    wt(12);
    rst <= 1'b0;
    wt(1);
    chk("error", 1, err);
    st(3'h2);
    rd(`GSM_OFS_IRQ_EN, `GSM_RESP_OKAY);
    chk("irq_en", 0, d);
    rd(5'h14, `GSM_RESP_SLVERR);
    wr(`GSM_OFS_STATUS, 32'h1, `GSM_RESP_SLVERR);
    wr(`GSM_OFS_IRQ_EN, 32'hF, `GSM_RESP_OKAY);
    $display("reset and registers done");
    rel <= 1'b1;
    ena <= 1'b1;
    wt(6);
    st(3'h2);
    ena <= 1'b0;
    ack <= 1'b1;
    wt(6);
    st(3'h3);
    ack <= 1'b0;
    ena <= 1'b1;
    wt(6);
    st(3'h0);
    chk("irq", 1, irq);
    wr(`GSM_OFS_IRQ_CLR, 32'hF, `GSM_RESP_OKAY);
    chk("irq", 0, irq);
    ccmd <= 1'b1;
    wt(10);
    chk("close", 1, close_o);
    chk("sensors", 4'hC, sens_o);
    chk("plausible", 1, plaus);
    yank <= 1'b1;
    wt(1);
    yank <= 1'b0;
    wt(6);
    st(3'h0);
    $display("release done");
    estop <= 1'b1;
    wt(6);
    st(3'h1);
    chk("power", 1, pwr);
    ocmd <= 1'b1;
    wt(6);
    chk("open", 0, open_o);
    yank <= 1'b1;
    wt(1);
    yank <= 1'b0;
    wt(6);
    st(3'h2);
    chk("power", 0, pwr);
    chk("error", 1, err);
    chk("irq", 1, irq);
    estop <= 1'b0;
    ena <= 1'b0;
    wt(4);
    ena <= 1'b1;
    wt(6);
    st(3'h2);
    $display("hold and cutoff done");
    agree <= 1'b1;
    wt(4);
    conf <= 1'b1;
    wt(6);
    st(3'h4);
    chk("power", 1, pwr);
    conf <= 1'b0;
    wt(6);
    st(3'h2);
    chk("power", 0, pwr);
    $display("panic done");
    ce <= 1'b0;
    conf <= 1'b1;
    wt(6);
    chk("power", 0, pwr);
    conf <= 1'b0;
    ce <= 1'b1;
    ack <= 1'b1;
    ocmd <= 1'b0;
    wt(6);
    st(3'h3);
    ack <= 1'b0;
    ena <= 1'b0;
    wt(4);
    ena <= 1'b1;
    wt(6);
    st(3'h0);
    wr(`GSM_OFS_CTRL, 32'h1, `GSM_RESP_OKAY);
    st(3'h1);
    rd(`GSM_OFS_CTRL, `GSM_RESP_OKAY);
    chk("soft_stop", 1, d);
    wr(`GSM_OFS_CTRL, 32'h0, `GSM_RESP_OKAY);
    conf <= 1'b1;
    wt(6);
    st(3'h0);
    conf <= 1'b0;
    rd(`GSM_OFS_IRQ_STAT, `GSM_RESP_OKAY);
    chk("irq_stat", 32'hF, d);
    rd(`GSM_OFS_IRQ_CLR, `GSM_RESP_SLVERR);
    chk("clr_data", 0, d);
    $display("freeze and exits done");
    conclude;
  end
endmodule
